// ===== hdl/uart_rx_defines.vh
// Purpose: Constants for the receive buffer and status block.
// Assumes: APB byte addresses, 32-bit data words.
// Notes: Definitions only.
`ifndef UART_RX_DEFINES_VH
`define UART_RX_DEFINES_VH
`define OFS_STATUS_A 12'h000
`define OFS_CTRL_B 12'h004
`define OFS_CTRL_C 12'h008
`define OFS_DATA 12'h00C
`define OFS_RXSHIFT 12'h010
`define BIT_RXC 7
`define BIT_FE 4
`define BIT_DOR 3
`define BIT_UPE 2
`define BIT_RX_COMPLETE_IRQ_EN 7
`define BIT_RECEIVER_ENABLE 4
`define BIT_RECEIVED_NINTH_BIT 1
`define BIT_TRANSMIT_NINTH_BIT 0
`define BIT_UPM1 5
`define BIT_UPM0 4
`define BIT_STOP_BIT_SELECT 3
`define FLD_UCSZ_HI 2
`define FLD_UCSZ_LO 1
`define BIT_SZ2 2
`define SZ_NINE 3'h7
`define RST_CTRL_B 8'h00
`define RST_CTRL_C 8'h06
`define FIFO_DEPTH 2
`endif

// ===== hdl/uart_receive_buffer_flags.v
// Purpose: Receive FIFO, status flags, parity check and APB register file.
// Assumes: Bit recovery supplies decided bits and a start strobe synchronous to mclk.
// Notes: Registers answer with pready high in the access cycle, no wait states.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defines.vh"
module uart_receive_buffer_flags #(
  parameter DEPTH = `FIFO_DEPTH
) (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire globalIrqEn,
  input wire startDetect,
  input wire bitValid,
  input wire bitValue,
  output reg rxCompleteIrq,
  output reg receiverOwnsPin,
  output reg receiverActive,
  output reg [4:0] charSizeOut,
  output reg stopBitSelectOut
);
  localparam ST_IDLE = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_HELD = 3'h4;

  reg [2:0] state;
  reg [3:0] bitCount;
  reg [3:0] frameLen;
  reg [9:0] shiftData;
  reg [8:0] heldData;
  reg heldFrameErr;
  reg heldParErr;
  reg [8:0] fifoData [0:DEPTH-1];
  reg fifoFe [0:DEPTH-1];
  reg fifoPe [0:DEPTH-1];
  reg fifoDor [0:DEPTH-1];
  reg [1:0] count;
  reg rdPtr;
  reg wrPtr;
  reg overrunPending;
  reg rxCompleteIrqEn;
  reg receiverEnable;
  reg transmitNinthBit;
  reg [1:0] parityModeBits;
  reg stopBitSelect;
  reg [2:0] charSizeSetting;
  reg [31:0] next_prdata;
  integer k;

  wire wrAcc = psel & penable & pwrite & clkEn;
  wire rdAcc = psel & penable & ~pwrite & clkEn;
  wire dataRead = rdAcc & (paddr == `OFS_DATA) & (count != 2'h0);
  wire fifoFull = (count == DEPTH);
  wire pushHeld = (state == ST_HELD) & (~fifoFull | dataRead);

  // Data bits per character from the size setting; the ninth bit case covers 4 to 7.
  function [3:0] dataBits;
    input [2:0] sz;
    begin
      dataBits = sz[`BIT_SZ2] ? 4'h9 : {2'h0, sz[1:0]} + 4'h5;
    end
  endfunction

  // Bits shifted before the stop bit: the data bits plus the parity bit when checked.
  // Both the idle state and the back-to-back start in the holding state need this count.
  function [3:0] frameBits;
    input [2:0] sz;
    input parityOn;
    begin
      frameBits = dataBits(sz) + {3'h0, parityOn};
    end
  endfunction

  // Parity over the data bits only; bits above the character size are left out.
  function parityOf;
    input [8:0] d;
    input [3:0] n;
    integer i;
    begin
      parityOf = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n) begin
          parityOf = parityOf ^ d[i];
        end
      end
    end
  endfunction

  // Shift register: data, optional parity, then the first stop bit only.
  always @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitCount <= 4'h0;
      frameLen <= 4'h0;
      shiftData <= 10'h000;
      heldData <= 9'h000;
      heldFrameErr <= 1'b0;
      heldParErr <= 1'b0;
      overrunPending <= 1'b0;
    end else if (clkEn) begin
      if (!receiverEnable) begin
        state <= ST_IDLE;
        overrunPending <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (startDetect) begin
              state <= ST_SHIFT;
              bitCount <= 4'h0;
              frameLen <= frameBits(charSizeSetting, parityModeBits[1]);
              shiftData <= 10'h000;
            end
          end
          ST_SHIFT: begin
            if (bitValid) begin
              if (bitCount == frameLen) begin
                heldData <= shiftData[8:0] & ~(9'h1FF << dataBits(charSizeSetting));
                heldFrameErr <= ~bitValue;
                heldParErr <= parityModeBits[1] &
                  (parityOf(shiftData[8:0], dataBits(charSizeSetting)) ^ parityModeBits[0] ^
                  shiftData[dataBits(charSizeSetting)]);
                state <= ST_HELD;
              end else begin
                shiftData[bitCount] <= bitValue;
                bitCount <= bitCount + 4'h1;
              end
            end
          end
          // A start bit may follow the stop bit at once, so the held frame
          // leaves for the buffer in the same cycle as the next frame begins.
          // Ignoring that start bit would lose a frame while space was free.
          ST_HELD: begin
            if (pushHeld) begin
              overrunPending <= 1'b0;
              if (startDetect) begin
                state <= ST_SHIFT;
                bitCount <= 4'h0;
                frameLen <= frameBits(charSizeSetting, parityModeBits[1]);
                shiftData <= 10'h000;
              end else begin
                state <= ST_IDLE;
              end
            end else if (startDetect) begin
              // Buffer and holding stage are both full: the newest frame is
              // dropped and the held one carries the overrun mark into the buffer.
              overrunPending <= 1'b1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Two-entry FIFO; flags are stored per entry so a data read advances them together.
  always @(posedge mclk) begin
    if (sys_rst) begin
      count <= 2'h0;
      rdPtr <= 1'b0;
      wrPtr <= 1'b0;
      // Entries start defined so that no unknown can reach a status read.
      for (k = 0; k < DEPTH; k = k + 1) begin
        fifoData[k] <= 9'h000;
        fifoFe[k] <= 1'b0;
        fifoPe[k] <= 1'b0;
        fifoDor[k] <= 1'b0;
      end
    end else if (clkEn) begin
      if (!receiverEnable) begin
        count <= 2'h0;
        rdPtr <= 1'b0;
        wrPtr <= 1'b0;
      end else begin
        if (pushHeld) begin
          fifoData[wrPtr] <= heldData;
          fifoFe[wrPtr] <= heldFrameErr;
          fifoPe[wrPtr] <= heldParErr;
          fifoDor[wrPtr] <= overrunPending;
          wrPtr <= ~wrPtr;
        end
        if (dataRead) begin
          rdPtr <= ~rdPtr;
        end
        // A push and a pop in one cycle leave the fill level as it was.
        case ({pushHeld, dataRead})
          2'b10: count <= count + 2'h1;
          2'b01: count <= count - 2'h1;
          default: count <= count;
        endcase
      end
    end
  end

  // Writes to status A touch no error flag.
  always @(posedge mclk) begin
    if (sys_rst) begin
      rxCompleteIrqEn <= 1'b0;
      receiverEnable <= 1'b0;
      transmitNinthBit <= 1'b0;
      parityModeBits <= 2'h0;
      stopBitSelect <= 1'b0;
      charSizeSetting <= 3'h3;
    end else if (wrAcc) begin
      if (paddr == `OFS_CTRL_B) begin
        rxCompleteIrqEn <= pwdata[`BIT_RX_COMPLETE_IRQ_EN];
        receiverEnable <= pwdata[`BIT_RECEIVER_ENABLE];
        transmitNinthBit <= pwdata[`BIT_TRANSMIT_NINTH_BIT];
        charSizeSetting[2] <= pwdata[`BIT_SZ2];
      end
      if (paddr == `OFS_CTRL_C) begin
        parityModeBits <= {pwdata[`BIT_UPM1], pwdata[`BIT_UPM0]};
        stopBitSelect <= pwdata[`BIT_STOP_BIT_SELECT];
        charSizeSetting[1:0] <= pwdata[`FLD_UCSZ_HI:`FLD_UCSZ_LO];
      end
    end
  end

  // Error flags and the ninth bit come from the entry at the read position, so
  // software must read status and control before the data word moves it on.
  // An empty buffer reads all flags as zero rather than stale entry contents.
  always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
      `OFS_STATUS_A: begin
        next_prdata[`BIT_RXC] = (count != 2'h0);
        if (count != 2'h0) begin
          next_prdata[`BIT_FE] = fifoFe[rdPtr];
          next_prdata[`BIT_DOR] = fifoDor[rdPtr];
          next_prdata[`BIT_UPE] = fifoPe[rdPtr];
        end
      end
      `OFS_CTRL_B: begin
        next_prdata[`BIT_RX_COMPLETE_IRQ_EN] = rxCompleteIrqEn;
        next_prdata[`BIT_RECEIVER_ENABLE] = receiverEnable;
        next_prdata[`BIT_SZ2] = charSizeSetting[2];
        next_prdata[`BIT_RECEIVED_NINTH_BIT] = (count != 2'h0) & fifoData[rdPtr][8];
        next_prdata[`BIT_TRANSMIT_NINTH_BIT] = transmitNinthBit;
      end
      `OFS_CTRL_C: begin
        next_prdata[`BIT_UPM1] = parityModeBits[1];
        next_prdata[`BIT_UPM0] = parityModeBits[0];
        next_prdata[`BIT_STOP_BIT_SELECT] = stopBitSelect;
        next_prdata[`FLD_UCSZ_HI:`FLD_UCSZ_LO] = charSizeSetting[1:0];
      end
      `OFS_DATA: begin
        if (count != 2'h0) begin
          next_prdata[7:0] = fifoData[rdPtr][7:0];
        end
      end
      `OFS_RXSHIFT: begin
        next_prdata[2:0] = state;
      end
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Read data is registered in the setup cycle so it stands during the access cycle.
  always @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rxCompleteIrq <= 1'b0;
      receiverOwnsPin <= 1'b0;
      receiverActive <= 1'b0;
      charSizeOut <= 5'h00;
      stopBitSelectOut <= 1'b0;
    end else if (clkEn) begin
      prdata <= next_prdata;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `OFS_RXSHIFT);
      rxCompleteIrq <= rxCompleteIrqEn & globalIrqEn & (count != 2'h0);
      receiverOwnsPin <= receiverEnable;
      receiverActive <= (state == ST_SHIFT);
      charSizeOut <= {1'b0, dataBits(charSizeSetting)};
      stopBitSelectOut <= stopBitSelect;
    end
  end
endmodule // uart_receive_buffer_flags
`default_nettype wire

// ===== verif/serial_tx_model.sv
// Purpose: Far-end transmitter model handing decided bits to the block.
// Assumes: send is entered just after a rising edge of mclk.
// Notes: Between bits the data line shows the inverse of the last bit.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input wire logic mclk,
  output logic startDetect,
  output logic bitValid,
  output logic bitValue
);
  initial begin
    startDetect = 1'b0;
    bitValid = 1'b0;
    bitValue = 1'b0;
  end
  // Only the first stop bit is presented, since a second one never reaches the buffer.
  task automatic send(input logic [10:0] f, input int n, input int gap);
    startDetect <= 1'b1;
    @(posedge mclk) startDetect <= 1'b0;
    repeat (gap) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      bitValid <= 1'b1;
      bitValue <= f[i];
      @(posedge mclk);
      if (gap > 0 || i == n - 1) begin
        bitValid <= 1'b0;
        bitValue <= !f[i];
        repeat (gap) @(posedge mclk);
      end
    end
  endtask
endmodule // serial_tx_model
`default_nettype wire

// ===== verif/rx_buf_properties.sv
// Purpose: Port properties of the receive buffer block.
// Assumes: clkEn high while checked.
// Notes: Bound below the module.
`timescale 1ns/1ps
`default_nettype none
module rx_buf_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic globalIrqEn,
  input wire logic rxCompleteIrq,
  input wire logic receiverOwnsPin,
  input wire logic receiverActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic wrB = psel && penable && pwrite && clkEn && paddr == 12'h004;
  wire logic enBit = pwdata[4];
  a_ready_access: assert property (psel && !penable && clkEn |=> pready) else $error("no ready");
  a_idle_quiet: assert property (!psel |-> !pready) else $error("ready when idle");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h010 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access");
  a_pin_follows: assert property (wrB |=> ##1 receiverOwnsPin == $past(enBit, 2)) else $error("pin");
  a_disable_flush: assert property (wrB && !enBit |=> ##1 !rxCompleteIrq && !receiverActive)
    else $error("flush");
  a_irq_gated: assert property (rxCompleteIrq |-> $past(globalIrqEn)) else $error("irq gate");
  a_irq_needs_pin: assert property (rxCompleteIrq |-> receiverOwnsPin) else $error("irq off");
  a_active_needs_pin: assert property (receiverActive |-> receiverOwnsPin) else $error("active");
endmodule // rx_buf_properties
bind uart_receive_buffer_flags rx_buf_properties props (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .globalIrqEn(globalIrqEn), .rxCompleteIrq(rxCompleteIrq),
  .receiverOwnsPin(receiverOwnsPin), .receiverActive(receiverActive));
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the receive buffer block.
// Assumes: Zero-wait APB slave; clkEn tied high.
// Notes: Random formats plus overrun and disable cases.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, globalIrqEn = 1'b0;
  logic pready, pslverr, rxCompleteIrq, startDetect, bitValid, bitValue, stp, bad, e, sso;
  logic [4:0] cso;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [8:0] d;
  logic [2:0] sz;
  logic [1:0] pm;
  int fails = 0, checks = 0, seed = 32'h1839, n;
  initial forever #12.5 mclk = ~mclk;
  uart_receive_buffer_flags uut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .globalIrqEn(globalIrqEn), .startDetect(startDetect), .bitValid(bitValid),
    .bitValue(bitValue), .rxCompleteIrq(rxCompleteIrq), .receiverOwnsPin(), .receiverActive(),
    .charSizeOut(cso), .stopBitSelectOut(sso));
  serial_tx_model mdl (.mclk(mclk), .startDetect(startDetect), .bitValid(bitValid), .bitValue(bitValue));
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk) penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      tally_and_finish;
    end
    @(posedge mclk);
  endtask
  // Data bits first, then the parity bit when checking is on, then one stop bit.
  function automatic logic [10:0] frame_of(logic [8:0] dd, int nn, logic [1:0] p, logic s, logic e);
    logic [10:0] f;
    f = {2'b0, dd};
    if (p[1]) begin
      f[nn] = ^dd ^ p[0] ^ e;
      nn++;
    end
    f[nn] = s;
    return f;
  endfunction
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 12'h020, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    repeat (40) begin
      sz = $random(seed);
      if (sz > 3) sz = 3'h7;
      pm = $random(seed);
      if (pm == 2'h1) pm = 2'h0;
      {stp, bad} = $random(seed);
      n = (sz == 3'h7) ? 9 : 5 + sz;
      d = $random(seed) & ((1 << n) - 1);
      apb(1'b1, 12'h008, {26'h0, pm, stp ^ bad, sz[1:0], 1'b0});
      apb(1'b1, 12'h004, {24'h0, 1'b1, 2'b00, 1'b1, 1'b0, sz[2], 2'b00});
      globalIrqEn <= 1'($random(seed));
      mdl.send(frame_of(d, n, pm, stp, bad), n + pm[1] + 1, $random(seed) & 3);
      repeat (3) @(posedge mclk);
      chk(rxCompleteIrq, globalIrqEn);
      chk(cso, n);
      chk(sso, stp ^ bad);
      apb(1'b0, 12'h000, 32'h0);
      chk(r & 8'h9C, {1'b1, 2'b0, !stp, 1'b0, pm[1] & bad, 2'b0});
      apb(1'b0, 12'h004, 32'h0);
      if (sz == 3'h7) chk(r[1], d[8]);
      apb(1'b0, 12'h00C, 32'h0);
      chk(r, {23'h0, 1'b0, d[7:0]});
      apb(1'b0, 12'h000, 32'h0);
      chk(r[7], 1'b0);
    end
    apb(1'b1, 12'h008, 32'h06);
    apb(1'b1, 12'h004, 32'h90);
    for (int j = 0; j < 4; j++) mdl.send(11'h1A1 + j, 9, 0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b0, 12'h000, 32'h0);
      chk(r[3], j == 2);
      apb(1'b0, 12'h00C, 32'h0);
      chk(r, 32'hA1 + j);
    end
    mdl.send(11'h1A5, 9, 0);
    repeat (3) @(posedge mclk);
    apb(1'b1, 12'h000, 32'h1C);
    apb(1'b0, 12'h000, 32'h0);
    chk(r & 8'h9C, 8'h80);
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h004, 32'h90);
    apb(1'b0, 12'h000, 32'h0);
    chk(r[7], 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(r, 32'h0);
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
